// ### hdl/asp_pkg.sv
// Shared constants for the sample output port of the pipelined converter.
package asp_pkg;

	// ------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------
	localparam int ASP_DATA_W = 12;
	// Pipeline latency is not specified; this depth is a plain default
	localparam int ASP_PIPE_DEPTH = 6;
	localparam int ASP_CNT_W = 8;

	// ------------------------------------------------------------
	// Values after reset, and the counter's saturation limit
	// ------------------------------------------------------------
	localparam logic [ASP_DATA_W-1:0] ASP_WORD_RST = 12'h000;
	localparam logic [ASP_CNT_W-1:0] ASP_CNT_RST = 8'h00;
	localparam logic [ASP_CNT_W-1:0] ASP_CNT_MAX = 8'hff;

endpackage : asp_pkg

// ### hdl/asp_pipe.sv
// Conversion pipeline: words and valid flags advance one stage per sample.
`timescale 1ns/1ps
module asp_pipe
	import asp_pkg::*;
#(
	parameter int W = ASP_DATA_W,
	parameter int DEPTH = ASP_PIPE_DEPTH
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic shift_i,
	input wire logic flush_i,
	input wire logic [W-1:0] word_i,
	input wire logic valid_i,
	output logic [W-1:0] word_o,
	output logic valid_o
);

	logic [W-1:0] stage_word [DEPTH];
	logic [DEPTH-1:0] stage_valid;

	// ------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_stage
			logic [W-1:0] stage_in;
			// Chosen at elaboration so stage 0 never names an index below the array
			if (g == 0) begin : g_first
				assign stage_in = word_i;
			end else begin : g_next
				assign stage_in = stage_word[g-1];
			end
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					stage_word[g] <= W'(ASP_WORD_RST);
				end else if (shift_i) begin
					stage_word[g] <= stage_in;
				end
			end
		end
	endgenerate

	// Flush clears only the flags; stale words are harmless once marked invalid
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stage_valid <= '0;
		end else if (flush_i) begin
			stage_valid <= '0;
		end else if (shift_i) begin
			stage_valid <= {stage_valid[DEPTH-2:0], valid_i};
		end
	end

	assign word_o = stage_word[DEPTH-1];
	assign valid_o = stage_valid[DEPTH-1];

endmodule : asp_pipe

// ### hdl/asp_sample_port.sv
// Top of the converter's digital side: sampling, pipeline, output drive.
`timescale 1ns/1ps
module asp_sample_port
	import asp_pkg::*;
#(
	parameter int W = ASP_DATA_W,
	parameter int DEPTH = ASP_PIPE_DEPTH
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic sample_clk_i,
	input wire logic out_enable_n_i,
	input wire logic power_down_request_i,
	input wire logic [W-1:0] analog_code_i,
	output logic [W-1:0] sample_word_out_o,
	output logic [W-1:0] sample_word_oe_o,
	output logic sample_valid_o,
	output logic powered_down_o
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic sclk_s1, sclk_s2, sclk_s3;
	logic oe_n_s1, oe_n_s2;
	logic pd_s1, pd_s2;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
		end else begin
			sclk_s1 <= sample_clk_i;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
		end
	end

	// Enable and power-down come up released and powered down, the safe side
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oe_n_s1 <= 1'b1;
			oe_n_s2 <= 1'b1;
			pd_s1 <= 1'b1;
			pd_s2 <= 1'b1;
		end else begin
			oe_n_s1 <= out_enable_n_i;
			oe_n_s2 <= oe_n_s1;
			pd_s1 <= power_down_request_i;
			pd_s2 <= pd_s1;
		end
	end

	// ------------------------------------------------------------
	// Sampling
	// ------------------------------------------------------------
	logic sample_rise;
	logic sample_take;
	logic [W-1:0] held_word;
	logic held_valid;
	logic [W-1:0] tail_word;
	logic tail_valid;
	logic [ASP_CNT_W-1:0] take_cnt;

	assign sample_rise = sclk_s2 && !sclk_s3;
	assign sample_take = sample_rise && !powered_down_o;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			powered_down_o <= 1'b1;
		end else begin
			powered_down_o <= pd_s2;
		end
	end

	// Sample-and-hold; the sign bit flip turns two's complement into offset binary
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			held_word <= ASP_WORD_RST;
			held_valid <= 1'b0;
		end else if (powered_down_o) begin
			held_valid <= 1'b0;
		end else if (sample_take) begin
			held_word <= {~analog_code_i[W-1], analog_code_i[W-2:0]};
			held_valid <= 1'b1;
		end
	end

	asp_pipe #(
		.W(W),
		.DEPTH(DEPTH)
	) u_pipe (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.shift_i(sample_take),
		.flush_i(powered_down_o),
		.word_i(held_word),
		.valid_i(held_valid),
		.word_o(tail_word),
		.valid_o(tail_valid)
	);

	// Takes since the last flush, saturating at ASP_CNT_MAX; read only by the checks (no-fall, flush and latency)
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			take_cnt <= ASP_CNT_RST;
		end else if (powered_down_o) begin
			take_cnt <= ASP_CNT_RST;
		end else if (sample_take && take_cnt != ASP_CNT_MAX) begin
			take_cnt <= take_cnt + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Output word and drive
	// ------------------------------------------------------------
	// Word holds through power-down so a late reader still sees the last result
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sample_word_out_o <= ASP_WORD_RST;
			sample_valid_o <= 1'b0;
		end else begin
			sample_valid_o <= sample_take && tail_valid;
			if (sample_take && tail_valid) begin
				sample_word_out_o <= tail_word;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sample_word_oe_o <= '0;
		end else begin
			sample_word_oe_o <= {W{!oe_n_s2}};
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_no_fall_sample;
		@(posedge clk_i) disable iff (!arst_n_i)
		(!sclk_s2 && sclk_s3 && !powered_down_o) |=> $stable(held_word) && $stable(take_cnt);
	endproperty
	a_no_fall_sample: assert property (p_no_fall_sample)
		else $error("sample taken on a falling edge");

	property p_offset_code;
		@(posedge clk_i) disable iff (!arst_n_i)
		sample_take |=> held_word == {~$past(analog_code_i[W-1]), $past(analog_code_i[W-2:0])};
	endproperty
	a_offset_code: assert property (p_offset_code)
		else $error("held word not offset binary of input");

	property p_drive_on;
		@(posedge clk_i) disable iff (!arst_n_i)
		(!out_enable_n_i) [*5] |-> (&sample_word_oe_o);
	endproperty
	a_drive_on: assert property (p_drive_on)
		else $error("pins not driven while enable low");

	property p_drive_off;
		@(posedge clk_i) disable iff (!arst_n_i)
		out_enable_n_i [*4] |-> (sample_word_oe_o == '0);
	endproperty
	a_drive_off: assert property (p_drive_off)
		else $error("pins driven while enable high");

	property p_pd_enter;
		@(posedge clk_i) disable iff (!arst_n_i)
		power_down_request_i [*4] |-> powered_down_o ##1 !sample_valid_o;
	endproperty
	a_pd_enter: assert property (p_pd_enter)
		else $error("conversion continued in power-down");

	property p_pd_flush;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(powered_down_o) |=> !held_valid && !tail_valid && take_cnt == ASP_CNT_RST;
	endproperty
	a_pd_flush: assert property (p_pd_flush)
		else $error("pipeline not flushed on power-down");

	property p_active;
		@(posedge clk_i) disable iff (!arst_n_i)
		(!power_down_request_i) [*5] |-> !powered_down_o;
	endproperty
	a_active: assert property (p_active)
		else $error("not active with power-down low");

	property p_word_out;
		@(posedge clk_i) disable iff (!arst_n_i)
		(sample_take && tail_valid) |=> sample_valid_o && sample_word_out_o == $past(tail_word);
	endproperty
	a_word_out: assert property (p_word_out)
		else $error("word not delivered on sample");

	property p_latency;
		@(posedge clk_i) disable iff (!arst_n_i)
		sample_valid_o |-> take_cnt >= ASP_CNT_W'(DEPTH + 2);
	endproperty
	a_latency: assert property (p_latency)
		else $error("word out before pipeline latency");

endmodule : asp_sample_port

// ### tb/asp_capture_model.sv
// Far-side capture logic: makes the sample clock and resolves the shared data bus.
`timescale 1ns/1ps
module asp_capture_model
	import asp_pkg::*;
(
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [ASP_DATA_W-1:0] word_i,
	input wire logic [ASP_DATA_W-1:0] oe_i,
	output logic sample_clk_o,
	output logic [ASP_DATA_W-1:0] bus_o
);
	int ph = 0;
	logic [ASP_DATA_W-1:0] last = 12'h000;

	// ------------------------------------------------------------
	// Sample clock
	// ------------------------------------------------------------
	// 10 MHz: 25 system cycles a period; a started period always completes
	always @(posedge clk_i) begin
		if (ph != 0 || run_i) begin
			ph <= (ph == 24) ? 0 : ph + 1;
		end
	end
	assign sample_clk_o = (ph >= 1 && ph <= 12);

	// ------------------------------------------------------------
	// Bus
	// ------------------------------------------------------------
	// No pull on the bus, so a released line shows the inverse of its last level
	always @(posedge clk_i) begin
		if (|oe_i) begin
			last <= word_i;
		end
	end
	assign bus_o = (oe_i & word_i) | (~oe_i & ~last);
endmodule : asp_capture_model

// ### tb/testbench.sv
// Self-checking bench for the converter's sample output port.
`timescale 1ns/1ps
module testbench;
	import asp_pkg::*;
	localparam int LAT = ASP_PIPE_DEPTH + 1;
	logic clk_i, arst_n_i, run, sclk, oe_n, pd, valid, pdo;
	logic sclk_q = 1'b0;
	logic [ASP_DATA_W-1:0] word, oe, bus;
	logic [ASP_DATA_W-1:0] code = 12'h800;
	logic [15:0] lf = 16'hcba2;
	logic [ASP_DATA_W-1:0] expq[$];
	int err_count = 0, n_compared = 0, n_valid = 0, n_take = 0, hi_cnt = 0, prev;

	asp_sample_port #(.W(ASP_DATA_W), .DEPTH(ASP_PIPE_DEPTH)) dut (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .sample_clk_i(sclk), .out_enable_n_i(oe_n),
		.power_down_request_i(pd), .analog_code_i(code), .sample_word_out_o(word),
		.sample_word_oe_o(oe), .sample_valid_o(valid), .powered_down_o(pdo));
	asp_capture_model cap (.clk_i(clk_i), .run_i(run), .word_i(word), .oe_i(oe),
		.sample_clk_o(sclk), .bus_o(bus));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic check(input logic [ASP_DATA_W-1:0] seen, input logic [ASP_DATA_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize

	// Run n sample periods, then idle 40 cycles; the pipeline does not drain without samples
	task automatic takes(input int n);
		int goal;
		int i;
		goal = n_take + n;
		run <= 1'b1;
		for (i = 0; i < n * 40 && n_take < goal; i++) @(posedge clk_i);
		run <= 1'b0;
		if (n_take < goal) begin
			err_count++;
			summarize();
		end else repeat (40) @(posedge clk_i);
	endtask : takes

	// ------------------------------------------------------------
	// Stimulus and expectations
	// ------------------------------------------------------------
	// Code set at the fall is the one due; a second change mid-high must be ignored
	always @(posedge clk_i) begin
		sclk_q <= sclk;
		hi_cnt <= sclk ? hi_cnt + 1 : 0;
		if (sclk && !sclk_q) begin
			n_take <= n_take + 1;
			if (pd === 1'b0) expq.push_back({~code[11], code[10:0]});
		end
		if (hi_cnt == 6) code <= lf[11:0] ^ 12'h5a5;
		if (!sclk && sclk_q) begin
			lf <= lfsr(lf);
			code <= (n_take == 1) ? 12'h7ff : lf[11:0];
		end
	end

	always @(posedge clk_i) begin
		if (arst_n_i && valid === 1'b1) begin
			n_valid <= n_valid + 1;
			if (expq.size() == 0) check(12'h001, 12'(expq.size()));
			else check(bus, expq.pop_front());
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		arst_n_i = 1'b0;
		run = 1'b0;
		oe_n = 1'b0;
		pd = 1'b0;
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		check({11'h000, pdo}, 12'h000);
		check(oe, 12'hfff);
		takes(20);
		check(12'(n_valid), 12'(20 - LAT));
		check(12'(expq.size()), 12'(LAT));
		$display("test stream done");
		oe_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		check(oe, 12'h000);
		oe_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		check(oe, 12'hfff);
		$display("test output enable done");
		pd <= 1'b1;
		repeat (6) @(posedge clk_i);
		check({11'h000, pdo}, 12'h001);
		expq.delete();
		prev = n_valid;
		takes(10);
		check(12'(n_valid - prev), 12'h000);
		pd <= 1'b0;
		repeat (6) @(posedge clk_i);
		check({11'h000, pdo}, 12'h000);
		takes(15);
		check(12'(n_valid - prev), 12'(15 - LAT));
		$display("test power down done");
		summarize();
	end
endmodule : testbench
